//--- hdl/ssx_sync_serial.v
// What this block does
// R1: after start, shift each transmit word out LSB first with the serial clock
// R2: right after a word's last bit, load the next buffer word into the shifter
// R3: transmit: pulse the done interrupt when the word count is sent
// R4: internal clock transmit: stop clock at block end unless refilled; one write releases
// R5: a write to any buffer, used or spare, releases the wait
// R6: external clock transmit: host refills the buffer before the next word shifts
// R7: start cleared while sending: finish the current word, then drop active flag
// R8: abort control ends the transfer at once and drops the active flag
// R9: external transmit not refilled and still started: send dummy word, then end
// R10: host changes word count only after stopping and seeing active flag low
// R11: receive: shift in, store each word, interrupt when the count is received
// R12: internal receive: stop clock while previous block unread; one read avoids it
// R13: a read of any buffer, used or spare, releases the receive wait
// R14: external receive with unread data: do not store, cancel reception
// R15: start cleared while receiving: store current word, stop, drop active flag
// R16: abort during reception discards the partial word
// R17: host rewrites word count during the receive wait before reading data
// R18: a mode switch drops the buffer state
// R19: transmit/receive is 8-bit, drive on leading edges, sample on trailing edges
// R20: host reads all received words before writing new transmit words
// R21: internal transmit/receive waits for a new transmit write; one write avoids it
// R22: transmit/receive: start cleared ends after the final bit, then flag drops
// R23: word count code 0..7 means one to eight words from the lowest buffer up
// R24: 4-bit transfers use low nibble, receive stores zero upper nibble
// R25: after reset idle, flag low, no wait, serial clock output high
`timescale 1ns/100ps
`include "ssx_consts.vh"
module ssx_sync_serial (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // avalon-mm slave
  input wire [5:0] avs_address_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // serial link
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe_n_o,
  output wire so_o,
  input wire si_i,
  // event
  output wire serial_done_irq_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam [7:0] C1_RST = `SSX_C1_RST;
  localparam [7:0] C2_RST = `SSX_C2_RST;

  reg [1:0] state_ff;
  reg transfer_start_ctl_ff;
  reg transfer_abort_ctl_ff;
  reg [1:0] transfer_mode_select_ff;
  reg wide_ff;
  reg [2:0] csel_ff;
  reg [2:0] cnt_ff;
  reg [1:0] frame_wait_ff;
  reg [2:0] idx_ff;
  reg [2:0] bit_ff;
  reg [7:0] txsh_ff;
  reg [7:0] rxsh_ff;
  reg so_ff;
  reg sck_ff;
  reg [15:0] div_ff;
  reg wr_seen_ff;
  reg rd_seen_ff;
  reg dummy_ff;
  reg pend_ff;
  reg irq_ff;
  reg rd_done_ff;
  reg rd_buf_ff;
  reg [7:0] rd_reg_ff;
  reg sck_s1_ff;
  reg sck_s2_ff;
  reg sck_s3_ff;
  reg si_s1_ff;
  reg si_s2_ff;

  wire [7:0] mem_a_q;
  wire [7:0] mem_b_q;

  // bus decode
  wire [3:0] widx = avs_address_i[5:2];
  wire sel_buf = avs_address_i[`SSX_BUF_SEL_BIT];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire ext = (csel_ff == `SSX_CSEL_EXT);
  wire is_tx = (transfer_mode_select_ff != `SSX_MODE_RX);
  wire is_rx = (transfer_mode_select_ff != `SSX_MODE_TX);
  wire mode_rx = (transfer_mode_select_ff == `SSX_MODE_RX);
  wire wide_eff = wide_ff | (transfer_mode_select_ff == `SSX_MODE_TXRX); // see R19
  wire [2:0] last_bit = wide_eff ? 3'h7 : 3'h3;
  wire store;
  wire wr_stall = avs_write_i & sel_buf & store;
  wire wr_take = avs_write_i & ~wr_stall;
  wire rd_take = avs_read_i & rd_done_ff;
  wire be0 = avs_byteenable_i[0];
  wire buf_wr = wr_take & sel_buf & be0;
  wire buf_rd = rd_take & sel_buf;
  wire ctl1_wr = wr_take & ~sel_buf & be0 & (widx == `SSX_IDX_CTL_ONE);
  wire ctl2_wr = wr_take & ~sel_buf & be0 & (widx == `SSX_IDX_CTL_TWO);
  wire abort_now = transfer_abort_ctl_ff | (ctl1_wr & wd[`SSX_C1_ABORT]); // see R8
  wire go = ctl1_wr & wd[`SSX_C1_START] & ~wd[`SSX_C1_ABORT] & (state_ff == ST_IDLE);
  wire [1:0] wr_mode = wd[`SSX_C1_MODE_HI:`SSX_C1_MODE_LO];

  // serial clock edges: leading is the falling edge, trailing the rising edge
  wire [15:0] half = `SSX_HALF_BASE << csel_ff;
  wire tick = (div_ff == half - 16'h0001);
  wire shifting = (state_ff == ST_SHIFT);
  wire ext_lead = sck_s3_ff & ~sck_s2_ff;
  wire ext_trail = ~sck_s3_ff & sck_s2_ff;
  wire lead = shifting & (ext ? ext_lead : (tick & sck_ff));
  wire trail = shifting & (ext ? ext_trail : (tick & ~sck_ff));

  // word completion and block bookkeeping
  wire [7:0] rx_new = {si_s2_ff, rxsh_ff[7:1]};
  wire word_end = trail & (bit_ff == last_bit);
  wire rd_seen_eff = rd_seen_ff | buf_rd;
  wire wr_seen_eff = wr_seen_ff | buf_wr;
  // previous block still unread when the next block's first word lands
  wire blocked = mode_rx & (idx_ff == 3'h0) & ~rd_seen_eff; // see R12
  wire hold_pend = (state_ff == ST_HOLD) & pend_ff;
  wire commit = (word_end & ~blocked) | (hold_pend & (buf_rd | ~transfer_start_ctl_ff)); // see R13
  wire last = (idx_ff == cnt_ff); // see R23
  wire [7:0] rx_src = (state_ff == ST_HOLD) ? rxsh_ff : rx_new;
  wire [7:0] rx_word = wide_eff ? rx_src : {4'h0, rx_src[7:4]}; // see R24
  assign store = commit & is_rx & ~abort_now; // see R11
  wire [7:0] tx_word = dummy_ff ? `SSX_DUMMY_WORD : mem_b_q;

  ssx_word_mem #(
    .WIDTH(8),
    .ABITS(3)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(store | buf_wr),
    .waddr_i(store ? idx_ff : avs_address_i[4:2]),
    .wdata_i(store ? rx_word : wd),
    .raddr_a_i(avs_address_i[4:2]),
    .rdata_a_o(mem_a_q),
    .raddr_b_i(idx_ff),
    .rdata_b_o(mem_b_q)
  );

  // reads take two cycles because the buffer read data come from a register
  assign avs_waitrequest_o = (avs_read_i & ~rd_done_ff) | wr_stall;
  assign avs_readdata_o = {24'h000000, rd_buf_ff ? mem_a_q : rd_reg_ff};
  assign sck_o = sck_ff;
  assign sck_oe_n_o = ext; // see R25
  assign so_o = so_ff;
  assign serial_done_irq_o = irq_ff;

  // bus read capture
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_done_ff <= 1'b0;
      rd_buf_ff <= 1'b0;
      rd_reg_ff <= 8'h00;
    end
    else
    begin
      rd_done_ff <= avs_read_i & ~rd_done_ff;
      if (avs_read_i & ~rd_done_ff)
      begin
        rd_buf_ff <= sel_buf;
        if (sel_buf)
          rd_reg_ff <= 8'h00;
        else if (widx == `SSX_IDX_CTL_ONE)
          rd_reg_ff <= {transfer_start_ctl_ff, transfer_abort_ctl_ff,
                        transfer_mode_select_ff, wide_ff, csel_ff};
        else if (widx == `SSX_IDX_CTL_TWO)
          rd_reg_ff <= {3'h0, frame_wait_ff, cnt_ff};
        else if (widx == `SSX_IDX_STATUS)
          rd_reg_ff <= {state_ff != ST_IDLE, state_ff == ST_SHIFT, 6'h00};
        else
          rd_reg_ff <= 8'h00;
      end
    end
  end

  // pin synchronisers
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sck_s1_ff <= 1'b1;
      sck_s2_ff <= 1'b1;
      sck_s3_ff <= 1'b1;
      si_s1_ff <= 1'b1;
      si_s2_ff <= 1'b1;
    end
    else
    begin
      sck_s1_ff <= sck_i;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      si_s1_ff <= si_i;
      si_s2_ff <= si_s1_ff;
    end
  end

  // control registers and transfer engine
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= ST_IDLE; // see R25
      transfer_start_ctl_ff <= C1_RST[`SSX_C1_START];
      transfer_abort_ctl_ff <= 1'b0;
      transfer_mode_select_ff <= `SSX_MODE_TX;
      wide_ff <= 1'b0;
      csel_ff <= 3'h0;
      cnt_ff <= C2_RST[`SSX_C2_CNT_HI:`SSX_C2_CNT_LO];
      frame_wait_ff <= 2'h0;
      idx_ff <= 3'h0;
      bit_ff <= 3'h0;
      txsh_ff <= 8'h00;
      rxsh_ff <= 8'h00;
      so_ff <= 1'b1;
      sck_ff <= 1'b1;
      div_ff <= 16'h0000;
      wr_seen_ff <= 1'b0;
      rd_seen_ff <= 1'b0;
      dummy_ff <= 1'b0;
      pend_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= 1'b0;
      if (ctl2_wr)
      begin
        cnt_ff <= wd[`SSX_C2_CNT_HI:`SSX_C2_CNT_LO]; // see R10
        frame_wait_ff <= wd[`SSX_C2_WAIT_HI:`SSX_C2_WAIT_LO];
      end
      // internal divider runs only while shifting so a wait freezes the clock high
      if (shifting & ~ext)
      begin
        div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
        if (tick)
          sck_ff <= ~sck_ff;
      end
      if (lead & is_tx)
      begin
        if (bit_ff == 3'h0)
        begin
          txsh_ff <= tx_word; // see R2
          so_ff <= tx_word[0]; // see R1
        end
        else
          so_ff <= txsh_ff[bit_ff]; // see R1
      end
      if (trail)
      begin
        rxsh_ff <= rx_new; // see R19
        if (bit_ff != last_bit)
          bit_ff <= bit_ff + 3'h1;
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (go)
          begin
            state_ff <= ST_SHIFT;
            idx_ff <= 3'h0;
            bit_ff <= 3'h0;
            div_ff <= 16'h0000;
            sck_ff <= 1'b1;
            dummy_ff <= 1'b0;
            pend_ff <= 1'b0;
            rd_seen_ff <= 1'b1;
            wr_seen_ff <= 1'b0;
          end
        end
        ST_SHIFT, ST_HOLD:
        begin
          if (word_end & blocked)
          begin
            bit_ff <= 3'h0;
            if (ext)
            begin
              state_ff <= ST_IDLE; // see R14
              transfer_start_ctl_ff <= 1'b0;
            end
            else
            begin
              state_ff <= ST_HOLD; // see R12
              pend_ff <= 1'b1;
            end
          end
          else if (commit)
          begin
            bit_ff <= 3'h0;
            pend_ff <= 1'b0;
            div_ff <= 16'h0000;
            idx_ff <= last ? 3'h0 : idx_ff + 3'h1;
            if (last)
            begin
              irq_ff <= 1'b1; // see R3
              wr_seen_ff <= 1'b0;
              rd_seen_ff <= 1'b0;
            end
            if (~transfer_start_ctl_ff)
              state_ff <= ST_IDLE; // see R7
            else if (dummy_ff)
            begin
              state_ff <= ST_IDLE; // see R9
              transfer_start_ctl_ff <= 1'b0;
            end
            else if (last & is_tx & ~wr_seen_eff)
            begin
              if (~ext)
                state_ff <= ST_HOLD; // see R4
              else if (~is_rx)
              begin
                state_ff <= ST_SHIFT;
                dummy_ff <= 1'b1; // see R9
              end
              else
                state_ff <= ST_SHIFT; // see R6
            end
            else
              state_ff <= ST_SHIFT;
          end
          else if ((state_ff == ST_HOLD) & ~pend_ff)
          begin
            if (~transfer_start_ctl_ff)
              state_ff <= ST_IDLE; // see R22
            else if (buf_wr)
            begin
              state_ff <= ST_SHIFT; // see R5
              div_ff <= 16'h0000;
            end
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
      // set wins: a buffer access in the cycle of a block-end clear is kept
      if (buf_wr)
        wr_seen_ff <= 1'b1; // see R21
      if (buf_rd)
        rd_seen_ff <= 1'b1; // see R13
      // the write that releases a transmit wait is consumed by that release
      if ((state_ff == ST_HOLD) & ~pend_ff & buf_wr & transfer_start_ctl_ff)
        wr_seen_ff <= 1'b0; // see R4
      if (ctl1_wr)
      begin
        transfer_start_ctl_ff <= wd[`SSX_C1_START];
        transfer_abort_ctl_ff <= wd[`SSX_C1_ABORT];
        transfer_mode_select_ff <= wr_mode;
        wide_ff <= wd[`SSX_C1_WIDE];
        csel_ff <= wd[`SSX_C1_CSEL_HI:`SSX_C1_CSEL_LO];
        if (wr_mode != transfer_mode_select_ff)
        begin
          wr_seen_ff <= 1'b0; // see R18
          // a fresh start has no unread block, so it must not wait on its first word
          rd_seen_ff <= go;
        end
      end
      // abort overrides everything, partial data is dropped
      if (abort_now & (state_ff != ST_IDLE))
      begin
        state_ff <= ST_IDLE; // see R16
        pend_ff <= 1'b0;
        bit_ff <= 3'h0;
        dummy_ff <= 1'b0;
      end
      if ((state_ff != ST_IDLE) & (abort_now | (commit & ~transfer_start_ctl_ff)))
      begin
        sck_ff <= 1'b1; // see R15
        so_ff <= 1'b1;
      end
    end
  end
endmodule

//--- hdl/ssx_word_mem.v
`timescale 1ns/100ps
// word buffers: one write port, two registered read ports
module ssx_word_mem #(
  parameter WIDTH = 8,
  parameter ABITS = 3
) (
  // clock
  input wire clk_i,
  // write port
  input wire we_i,
  input wire [ABITS-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  // read ports
  input wire [ABITS-1:0] raddr_a_i,
  output reg [WIDTH-1:0] rdata_a_o,
  input wire [ABITS-1:0] raddr_b_i,
  output reg [WIDTH-1:0] rdata_b_o
);
  reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end
endmodule

//--- pkg/ssx_consts.vh
`ifndef SSX_CONSTS_VH
`define SSX_CONSTS_VH

// register word indexes (byte address = 4 * index)
`define SSX_IDX_CTL_ONE 4'h0
`define SSX_IDX_CTL_TWO 4'h1
`define SSX_IDX_STATUS 4'h2
// word buffers sit at indexes 8..15, picked out by this byte address bit
`define SSX_BUF_SEL_BIT 5

// serial_control_one fields
`define SSX_C1_START 7
`define SSX_C1_ABORT 6
`define SSX_C1_MODE_HI 5
`define SSX_C1_MODE_LO 4
`define SSX_C1_WIDE 3
`define SSX_C1_CSEL_HI 2
`define SSX_C1_CSEL_LO 0
`define SSX_C1_RST 8'h00

// transfer_mode_select codes
`define SSX_MODE_TX 2'h0
`define SSX_MODE_RX 2'h1
`define SSX_MODE_TXRX 2'h2

// clock select code for the external clock
`define SSX_CSEL_EXT 3'h7

// serial_control_two fields
`define SSX_C2_CNT_HI 2
`define SSX_C2_CNT_LO 0
`define SSX_C2_WAIT_HI 4
`define SSX_C2_WAIT_LO 3
`define SSX_C2_RST 8'h00

// serial_status_reg fields
`define SSX_ST_ACTIVE 7
`define SSX_ST_SHIFT 6

// data sent when the external host failed to refill the buffer
`define SSX_DUMMY_WORD 8'hff

// internal clock: half period in clk_i cycles at select 0, doubled per select step
`define SSX_HALF_BASE 16'h0002

`endif

//--- verif/ssx_partner.sv
`timescale 1ns/100ps
module ssx_partner (
  // serial pins
  input wire sck_i,
  input wire so_i,
  output reg si_o,
  output reg sck_o,
  // bench side
  input wire en_i,
  input wire [3:0] nbits_i,
  input wire [7:0] word_i,
  output reg [7:0] got_o,
  output reg stb_o
);
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;
  initial
  begin
    si_o = 1'b1;
    sck_o = 1'b1;
    stb_o = 1'b0;
    got_o = 8'h00;
    cnt_ff = 4'h0;
    sh_ff = 8'h00;
  end
  // external clock stands still high between frames
  task automatic frame(input int n);
    // step off the system clock edge so the pin never races the synchroniser
    #1;
    repeat (n)
    begin
      #80 sck_o = 1'b0;
      #80 sck_o = 1'b1;
    end
  endtask
  // idle data toggles so a stale bit is never mistaken for a good one
  always @(negedge sck_i)
    si_o <= en_i ? word_i[cnt_ff[2:0]] : ~si_o;
  always @(posedge sck_i)
  begin
    stb_o <= 1'b0;
    if (!en_i)
      cnt_ff <= 4'h0;
    else if (cnt_ff == nbits_i - 4'h1)
    begin
      cnt_ff <= 4'h0;
      got_o <= {so_i, sh_ff[7:1]} >> (4'h8 - nbits_i);
      stb_o <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 4'h1;
      sh_ff <= {so_i, sh_ff[7:1]};
    end
  end
endmodule

//--- verif/ssx_sync_serial_assertions.sv
`timescale 1ns/100ps
module ssx_sync_serial_assertions (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // bus
  input wire [5:0] avs_address_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // link
  input wire sck_i,
  input wire sck_o,
  input wire sck_oe_n_o,
  input wire so_o,
  input wire si_i,
  input wire serial_done_irq_o
);
  wire wr_ctl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
    && (avs_address_i[5:2] == 4'h0);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rd_wait_a:
    assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait state wrong");
  rst_idle_a:
    assert property ($rose(nrst_i) |-> sck_o && so_o && !serial_done_irq_o)
    else $error("not idle after reset");
  irq_pulse_a:
    assert property (serial_done_irq_o |=> !serial_done_irq_o)
    else $error("done pulse too long");
  irq_sck_a:
    assert property (serial_done_irq_o && !sck_oe_n_o |-> sck_o)
    else $error("done pulse while clock low");
  abort_idle_a:
    assert property (wr_ctl && avs_writedata_i[6] |-> ##2 (sck_o && so_o) [*4])
    else $error("abort left link busy");
  oe_sel_a:
    assert property (wr_ctl |-> ##2 sck_oe_n_o == ($past(avs_writedata_i[2:0], 2) == 3'h7))
    else $error("clock drive enable wrong");
  sck_half_a:
    assert property (!sck_oe_n_o && $fell(sck_o) |=> !sck_o)
    else $error("clock low phase too short");
  rdata_hi_a:
    assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule

//--- verif/ssx_sync_serial_tb.sv
`timescale 1ns/100ps
module ssx_sync_serial_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire wreq, sck_o, sck_oe_n, so, si, irq, p_sck, p_stb;
  wire [7:0] p_got;
  wire sck_w = sck_oe_n ? p_sck : sck_o;
  logic p_en = 1'b0;
  logic [3:0] p_nb = 4'h8;
  logic [7:0] p_word = 8'h00;
  logic so_chk = 1'b0;
  logic [31:0] seed = 32'heedb;
  logic [31:0] rd_val;
  logic [7:0] tw [0:2];
  logic [7:0] rd_q[$];
  logic [7:0] sw_q[$];
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  event rd_ev;
  always #2.5 clk_i = ~clk_i;
  ssx_sync_serial uut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .avs_address_i(adr),
    .avs_byteenable_i(4'hf),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wd),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .sck_i(sck_w),
    .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n),
    .so_o(so),
    .si_i(si),
    .serial_done_irq_o(irq)
  );
  ssx_partner u_p (
    .sck_i(sck_w),
    .so_i(so),
    .si_o(si),
    .sck_o(p_sck),
    .en_i(p_en),
    .nbits_i(p_nb),
    .word_i(p_word),
    .got_o(p_got),
    .stb_o(p_stb)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== {24'h0, e})
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk_i);
    // only the run timeout ends this wait
    while (wreq !== 1'b0)
      @(posedge clk_i);
    rd_val = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00);
    -> rd_ev;
  endtask
  task automatic wait_irq();
    while (irq !== 1'b1)
      @(negedge clk_i);
  endtask
  task automatic wait_idle();
    rd_val = 32'h80;
    while (rd_val[7] !== 1'b0)
      bus(1'b0, 6'h08, 8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(rd_ev)
    cmp("readdata", rd_q.pop_front(), rd_val);
  always @(posedge p_stb)
    if (so_chk)
      cmp("serial word", sw_q.pop_front(), {24'h0, p_got});
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("[FAIL] timeout exp done got hang");
      finish_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk(6'h00, 8'h00);
    rd_chk(6'h08, 8'h00);
    rd_chk(6'h0c, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      tw[k] = seed[7:0];
    end
    p_en <= 1'b1;
    so_chk = 1'b1;
    bus(1'b1, 6'h04, 8'h01);
    bus(1'b1, 6'h20, tw[0]);
    bus(1'b1, 6'h24, tw[1]);
    sw_q.push_back(tw[0]);
    sw_q.push_back(tw[1]);
    bus(1'b1, 6'h00, 8'h88);
    wait_irq();
    // a word leaving here would meet the wrong expectation
    repeat (60) @(posedge clk_i);
    sw_q.push_back(tw[2]);
    sw_q.push_back(tw[1]);
    bus(1'b1, 6'h20, tw[2]);
    wait_irq();
    bus(1'b1, 6'h00, 8'h08);
    wait_idle();
    rd_chk(6'h08, 8'h00);
    cmp("words left", 8'h00, sw_q.size());
    bus(1'b1, 6'h04, 8'h00);
    so_chk = 1'b0;
    $display("test transmit done");
    seed = lfsr(seed);
    p_word <= seed[7:0];
    p_nb <= 4'h4;
    // select 1: the two-flop input path needs more than two cycles per half period
    bus(1'b1, 6'h00, 8'h91);
    bus(1'b1, 6'h00, 8'h11);
    wait_idle();
    rd_chk(6'h20, {4'h0, seed[3:0]});
    // second block meets an unread first block and must hold the clock
    seed = lfsr(seed);
    p_word <= seed[7:0];
    bus(1'b1, 6'h00, 8'h91);
    wait_irq();
    repeat (120) @(posedge clk_i);
    rd_chk(6'h08, 8'h80);
    bus(1'b1, 6'h04, 8'h00);
    rd_chk(6'h24, tw[1]);
    wait_irq();
    bus(1'b1, 6'h00, 8'h11);
    wait_idle();
    rd_chk(6'h20, {4'h0, seed[3:0]});
    $display("test receive done");
    seed = lfsr(seed);
    p_word <= seed[15:8];
    p_nb <= 4'h8;
    so_chk = 1'b1;
    sw_q.push_back(seed[7:0]);
    bus(1'b1, 6'h20, seed[7:0]);
    bus(1'b1, 6'h00, 8'haf);
    bus(1'b1, 6'h00, 8'h2f);
    u_p.frame(8);
    wait_idle();
    rd_chk(6'h20, seed[15:8]);
    $display("test external duplex done");
    so_chk = 1'b0;
    bus(1'b1, 6'h00, 8'h8d);
    // land the abort in mid-word so the word in progress is really cut
    repeat (200) @(posedge clk_i);
    bus(1'b1, 6'h00, 8'h4d);
    rd_chk(6'h08, 8'h00);
    $display("test abort done");
    finish_test();
  end
endmodule
bind ssx_sync_serial ssx_sync_serial_assertions chk (.clk_i, .nrst_i, .avs_address_i,
  .avs_byteenable_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
  .avs_waitrequest_o, .sck_i, .sck_o, .sck_oe_n_o, .so_o, .si_i, .serial_done_irq_o);
